// *** hmc_counter.v ***
`timescale 1ns/10ps

// One general counter with enable and synchronous clear.
module hmc_counter #(
  parameter CW = 48,
  parameter INCW = 6
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire en_i,
  input wire clr_i,
  input wire [INCW-1:0] inc_i,
  output reg [CW-1:0] cnt_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_o <= {CW{1'b0}};
    end else if (ce_i) begin
      if (clr_i) begin
        cnt_o <= {CW{1'b0}};
      end else if (en_i) begin
        cnt_o <= cnt_o + {{(CW-INCW){1'b0}}, inc_i};
      end
    end
  end
endmodule

// *** hmc_event_sel.v ***
`timescale 1ns/10ps
`include "hmc_map.vh"

// Turns one control word and the occurrence signals into an increment.
module hmc_event_sel #(
  parameter CRW = 6,
  parameter INCW = 6
) (
  input wire [7:0] ev_code_i,
  input wire [7:0] umask_i,
  input wire [1:0] req_rd_i,
  input wire [1:0] req_wr_i,
  input wire [1:0] dir_probe_i,
  input wire [1:0] dir_upd_i,
  input wire [CRW-1:0] link2_addr_cred_i,
  input wire [CRW-1:0] link2_data_cred_i,
  input wire [3:0] starved_i,
  input wire [2:0] mem_rd_cnt_i,
  input wire [3:0] mem_wr_i,
  input wire zero_len_wb_i,
  input wire [2:0] spec_snoop_i,
  input wire [3:0] spec_early_i,
  input wire spec_early_any_i,
  output reg [INCW-1:0] inc_o
);
  always @* begin
    inc_o = {INCW{1'b0}};
    case (ev_code_i)
      `HMC_EV_REQUEST: inc_o = {{(INCW-1){1'b0}}, |({req_wr_i, req_rd_i} & umask_i[3:0])};
      `HMC_EV_DIR_PROBE: inc_o = {{(INCW-1){1'b0}}, |(dir_probe_i & umask_i[1:0])};
      `HMC_EV_DIR_UPDATE: inc_o = {{(INCW-1){1'b0}}, |(dir_upd_i & umask_i[1:0])};
      `HMC_EV_LINK2_ADDR: inc_o = link2_addr_cred_i[INCW-1:0];
      `HMC_EV_LINK2_DATA: inc_o = link2_data_cred_i[INCW-1:0];
      `HMC_EV_STARVED: inc_o = {{(INCW-1){1'b0}}, |(starved_i & umask_i[3:0])};
      `HMC_EV_MEM_READ: inc_o = umask_i[0] ? {{(INCW-3){1'b0}}, mem_rd_cnt_i} : {INCW{1'b0}};
      `HMC_EV_MEM_WRITE: inc_o = {{(INCW-1){1'b0}}, |(mem_wr_i & umask_i[3:0])};
      `HMC_EV_ZERO_LEN_WB: inc_o = {{(INCW-1){1'b0}}, zero_len_wb_i};
      `HMC_EV_SPEC_SNOOP: inc_o = {{(INCW-1){1'b0}}, |(spec_snoop_i & umask_i[3:1])};
      `HMC_EV_SPEC_EARLY: inc_o = {{(INCW-1){1'b0}},
        (umask_i[0] & spec_early_any_i) | (|(spec_early_i & umask_i[4:1]))};
      default: inc_o = {INCW{1'b0}};
    endcase
  end
endmodule

// *** hmc_map.vh ***
`ifndef HMC_MAP_VH
`define HMC_MAP_VH

// ==========================================================================
// Event codes.
`define HMC_EV_REQUEST 8'h01
`define HMC_EV_DIR_PROBE 8'h0c
`define HMC_EV_DIR_UPDATE 8'h0d
`define HMC_EV_MEM_READ 8'h17
`define HMC_EV_MEM_WRITE 8'h1a
`define HMC_EV_STARVED 8'h22
`define HMC_EV_SPEC_SNOOP 8'h53
`define HMC_EV_SPEC_EARLY 8'h54
`define HMC_EV_ZERO_LEN_WB 8'h58
`define HMC_EV_LINK2_ADDR 8'h59
`define HMC_EV_LINK2_DATA 8'h5a

// ==========================================================================
// Register byte offsets (counter control words then counter values).
`define HMC_OFF_CTRL0 8'h00
`define HMC_OFF_CTRL1 8'h04
`define HMC_OFF_CTRL2 8'h08
`define HMC_OFF_CTRL3 8'h0c
`define HMC_OFF_CNT0 8'h10
`define HMC_OFF_CNT1 8'h14
`define HMC_OFF_CNT2 8'h18
`define HMC_OFF_CNT3 8'h1c
`define HMC_OFF_STATUS 8'h20

// ==========================================================================
// Control word fields.
`define HMC_CTL_EV_LSB 0
`define HMC_CTL_EV_MSB 7
`define HMC_CTL_MASK_LSB 8
`define HMC_CTL_MASK_MSB 15
`define HMC_CTL_EN_BIT 22
`define HMC_CTL_RST_BIT 17
`define HMC_CTL_RESET 32'h0000_0000
`define HMC_CTL_WMASK 32'h0040_ffff

// Status register: bit 0 says the directory is implemented.
`define HMC_ST_DIR_BIT 0
`define HMC_BAD_ADDR_DATA 32'h0000_0000

`endif

// *** hmc_partner.sv ***
`timescale 1ns/10ps
// ==========
// Occurrence source
module hmc_partner (
  input wire clk_i,
  input wire act_i,
  input wire [44:0] occ_i,
  output reg [44:0] occ_o
);
  // Occurrences fall to zero between bursts, so a count does not depend on when it is read.
  initial occ_o = 45'h0;
  always @(posedge clk_i) begin
    occ_o <= act_i ? occ_i : 45'h0;
  end
endmodule

// *** hmc_top.v ***
// The Wishbone register port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "hmc_map.vh"

// Operation
// - Event 0x0c counts directory lookups; mask bit0 snoop-needed, bit1 snoop-not-needed.
// - Lookup is snoop-needed when directory bit set, otherwise not-needed.
// - Directory events are meaningful only where a directory exists.
// - Event 0x0d counts directory updates; bit0 sets, bit1 clears.
// - Set on remote read into remote cache; clear when all snoops invalid.
// - Event 0x59 accumulates link 2 address-channel ingress credits per cycle.
// - Event 0x5a accumulates link 2 block-data ingress credits per cycle.
// - Event 0x22 counts credit-starved cycles; bits 0-3 pick addr/data links.
// - Event 0x17 with mask bit0 adds normal reads issued, up to four.
// - Bypass-path reads are excluded from the memory read count.
// - Event 0x1a counts memory writes; bits 0-3 pick full/partial, isochronous or not.
// - Event 0x58 counts dropped zero-length modified-to-invalid writebacks.
// - Event 0x53 counts one per broadcasting request; bits 1-3 select sources.
// - Event 0x54 counts early clean returns; bit0 all, bits 1-4 subtypes.
// - Event 0x01 counts entering reads and writes of every kind.
// - Request mask bits 0-1 local/remote reads, bits 2-3 local/remote writes.
// - All but memory reads and link 2 credits add at most one; any counter 0-3.
module hmc_top #(
  parameter CW = 48,
  parameter CRW = 6,
  parameter NCNT = 4,
  parameter HAS_DIR = 1'b1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output wire ack_o,
  input wire [1:0] req_rd_i,
  input wire [1:0] req_wr_i,
  input wire dir_probe_i,
  input wire dir_bit_set_i,
  input wire remote_read_fill_i,
  input wire snoops_all_invalid_i,
  input wire [CRW-1:0] link2_addr_cred_i,
  input wire [CRW-1:0] link2_data_cred_i,
  input wire [3:0] starved_i,
  input wire [3:0] mem_rd_issue_i,
  input wire [3:0] mem_rd_bypass_i,
  input wire [3:0] mem_wr_i,
  input wire zero_len_wb_i,
  input wire [2:0] spec_snoop_i,
  input wire [3:0] spec_early_i,
  input wire spec_early_any_i
);
  localparam INCW = CRW;

  // ==========================================================================
  // Occurrence conditioning.
  wire [1:0] probe_class;
  wire [1:0] upd_class;
  wire [3:0] rd_norm;
  wire [2:0] rd_cnt;

  // Without a directory the lookup and update lines are forced quiet.
  assign probe_class = HAS_DIR ? {dir_probe_i & ~dir_bit_set_i, dir_probe_i & dir_bit_set_i} : 2'b00;
  assign upd_class = HAS_DIR ? {snoops_all_invalid_i, remote_read_fill_i} : 2'b00;
  assign rd_norm = mem_rd_issue_i & ~mem_rd_bypass_i;
  assign rd_cnt = {2'b00, rd_norm[0]} + {2'b00, rd_norm[1]} + {2'b00, rd_norm[2]} + {2'b00, rd_norm[3]};

  // ==========================================================================
  // Wishbone slave: single-cycle ack, registered read data.
  reg ack_r;
  wire req = cyc_i & stb_i;
  wire [2:0] idx = adr_i[4:2];
  wire is_ctrl = (adr_i[7:4] == 4'h0) & (adr_i[1:0] == 2'b00);
  wire is_cnt = (adr_i[7:4] == 4'h1) & (adr_i[1:0] == 2'b00);
  assign ack_o = ack_r;

  reg [31:0] ctrl_r [0:NCNT-1];
  wire [CW-1:0] cnt_w [0:NCNT-1];

  genvar g;
  generate
    for (g = 0; g < NCNT; g = g + 1) begin : ch
      wire [INCW-1:0] inc;
      wire wr_hit = req & we_i & ~ack_r & is_ctrl & (idx[1:0] == g);
      wire [31:0] bmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}} & `HMC_CTL_WMASK;
      always @(posedge clk_i) begin
        if (rst_i) begin
          ctrl_r[g] <= `HMC_CTL_RESET;
        end else if (ce_i) begin
          if (wr_hit) begin
            ctrl_r[g] <= (ctrl_r[g] & ~bmask) | (dat_i & bmask);
          end
        end
      end
      hmc_event_sel #(.CRW(CRW), .INCW(INCW)) u_sel (
        .ev_code_i(ctrl_r[g][`HMC_CTL_EV_MSB:`HMC_CTL_EV_LSB]),
        .umask_i(ctrl_r[g][`HMC_CTL_MASK_MSB:`HMC_CTL_MASK_LSB]),
        .req_rd_i(req_rd_i),
        .req_wr_i(req_wr_i),
        .dir_probe_i(probe_class),
        .dir_upd_i(upd_class),
        .link2_addr_cred_i(link2_addr_cred_i),
        .link2_data_cred_i(link2_data_cred_i),
        .starved_i(starved_i),
        .mem_rd_cnt_i(rd_cnt),
        .mem_wr_i(mem_wr_i),
        .zero_len_wb_i(zero_len_wb_i),
        .spec_snoop_i(spec_snoop_i),
        .spec_early_i(spec_early_i),
        .spec_early_any_i(spec_early_any_i),
        .inc_o(inc)
      );
      // Every event is offered to every counter.
      hmc_counter #(.CW(CW), .INCW(INCW)) u_cnt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(ctrl_r[g][`HMC_CTL_EN_BIT]),
        .clr_i(wr_hit & sel_i[2] & dat_i[`HMC_CTL_RST_BIT]),
        .inc_i(inc),
        .cnt_o(cnt_w[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Read path. Only the low 32 bits of each counter are visible; software
  // must tolerate wrap, traded for a single-word register map.
  reg [31:0] rd_nxt;
  always @* begin
    rd_nxt = `HMC_BAD_ADDR_DATA;
    if (is_ctrl) begin
      rd_nxt = ctrl_r[idx[1:0]];
    end else if (is_cnt) begin
      rd_nxt = cnt_w[idx[1:0]][31:0];
    end else if (adr_i == `HMC_OFF_STATUS) begin
      rd_nxt = {31'h0000_0000, HAS_DIR[0]};
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_r <= req & ~ack_r;
      if (req & ~ack_r & ~we_i) begin
        dat_o <= rd_nxt;
      end
    end
  end
endmodule

// *** hmc_top_asserts.sv ***
`timescale 1ns/10ps
// ==========
// Bus and register checks
module hmc_chk #(
  parameter HAS_DIR = 1'b1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [31:0] dat_o,
  input wire ack_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire rd_ack = ack_o && !we_i;
  take_ack_a: assert property (ce_i && cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
  ack_pulse_a: assert property (ce_i && ack_o |=> !ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(ack_o) |-> $past(cyc_i) && $past(stb_i)) else $error("ack uncaused");
  ack_held_a: assert property (ack_o |-> cyc_i && stb_i) else $error("ack without request");
  data_hold_a: assert property ($changed(dat_o) |-> rd_ack) else $error("read data moved");
  hole_zero_a: assert property (rd_ack && adr_i > 8'h20 |-> dat_o == 32'h0000_0000) else $error("hole read");
  ctrl_resv_a: assert property (rd_ack && adr_i < 8'h10 |-> (dat_o & 32'hffbf_0000) == 0) else $error("ctrl");
  dir_flag_a: assert property (rd_ack && adr_i == 8'h20 |-> dat_o[0] == HAS_DIR) else $error("dir flag");
endmodule
bind hmc_top hmc_chk #(.HAS_DIR(HAS_DIR)) u_hmc_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o));

// *** hmc_top_test.sv ***
`timescale 1ns/10ps
// ==========
// Bench
module hmc_top_test;
  reg clk_i = 0, rst_i = 1, ce_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, act = 0;
  reg [7:0] adr_i = 8'h00;
  reg [3:0] sel_i = 4'hf;
  reg [31:0] dat_i = 0, rd;
  reg [44:0] occ_i = 0;
  wire [44:0] o;
  wire [31:0] dat_o;
  wire ack_o;
  integer errors = 0, n_tests = 0;
  hmc_partner u_hmc_partner (.clk_i(clk_i), .act_i(act), .occ_i(occ_i), .occ_o(o));
  hmc_top u_hmc_top (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .req_rd_i(o[32:31]),
    .req_wr_i(o[30:29]), .dir_probe_i(o[28]), .dir_bit_set_i(o[27]), .remote_read_fill_i(o[26]),
    .snoops_all_invalid_i(o[25]), .link2_addr_cred_i(o[44:39]), .link2_data_cred_i(o[38:33]),
    .starved_i(o[24:21]), .mem_rd_issue_i(o[20:17]), .mem_rd_bypass_i(o[16:13]), .mem_wr_i(o[12:9]),
    .zero_len_wb_i(o[8]), .spec_snoop_i(o[7:5]), .spec_early_i(o[4:1]), .spec_early_any_i(o[0]));
  initial forever #20 clk_i = !clk_i;
  task results;
    begin
      $display("errors=%0d n_tests=%0d", errors, n_tests);
      if (errors == 0 && n_tests > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d);
    integer t;
    begin
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      dat_i <= d;
      t = 0;
      @(posedge clk_i);
      while (ack_o !== 1'b1 && t < 20) begin
        t = t + 1;
        @(posedge clk_i);
      end
      if (ack_o !== 1'b1) begin
        errors = errors + 1;
        results;
      end
      rd = dat_o;
      cyc_i <= 0;
      stb_i <= 0;
      @(posedge clk_i);
    end
  endtask
  // Clear, enable, run three busy cycles, then read the low count word.
  task ev(input [1:0] k, input [7:0] c, input [7:0] m, input [44:0] p, input [31:0] e);
    begin
      wb(1, {3'b000, k, 2'b00}, 32'h0002_0000);
      wb(1, {3'b000, k, 2'b00}, {16'h0040, m, c});
      occ_i <= p;
      act <= 1;
      repeat (3) @(posedge clk_i);
      act <= 0;
      repeat (3) @(posedge clk_i);
      wb(0, {3'b001, k, 2'b00}, 0);
      chk("count", e, rd);
    end
  endtask
  task t_regs;
    begin
      wb(0, 8'h00, 0);
      chk("ctrl0", 0, rd);
      wb(1, 8'h04, 32'hffff_ffff);
      wb(0, 8'h04, 0);
      chk("ctrl1", 32'h0040_ffff, rd);
      sel_i <= 4'h1;
      wb(1, 8'h04, 32'h0000_0000);
      sel_i <= 4'hf;
      wb(0, 8'h04, 0);
      chk("ctrl1_lane", 32'h0040_ff00, rd);
      wb(1, 8'h20, 0);
      wb(0, 8'h20, 0);
      chk("status", 1, rd & 1);
      wb(0, 8'h24, 0);
      chk("hole", 0, rd);
    end
  endtask
  task t_dir;
    begin
      ev(0, 8'h0c, 8'h01, 45'h3 << 27, 3);
      ev(1, 8'h0c, 8'h02, 45'h3 << 27, 0);
      ev(2, 8'h0c, 8'h02, 45'h1 << 28, 3);
      ev(3, 8'h0d, 8'h03, 45'h3 << 25, 3);
      ev(0, 8'h0d, 8'h02, 45'h1 << 26, 0);
    end
  endtask
  task t_link;
    begin
      ev(1, 8'h59, 8'h00, 45'h2a << 39, 126);
      ev(2, 8'h5a, 8'h00, 45'h5 << 33, 15);
      ev(3, 8'h22, 8'h08, 45'h7 << 21, 0);
      ev(0, 8'h22, 8'h0f, 45'h7 << 21, 3);
    end
  endtask
  task t_mem;
    begin
      ev(1, 8'h17, 8'h01, 45'hf5 << 13, 6);
      ev(2, 8'h17, 8'h01, 45'hf0 << 13, 12);
      ev(3, 8'h1a, 8'h0f, 45'ha << 9, 3);
      ev(0, 8'h58, 8'h00, 45'h1 << 8, 3);
    end
  endtask
  task t_spec;
    begin
      ev(1, 8'h53, 8'h02, 45'h6 << 5, 0);
      ev(2, 8'h53, 8'h0e, 45'h6 << 5, 3);
      ev(3, 8'h54, 8'h10, 45'h8 << 1, 3);
      ev(0, 8'h54, 8'h01, 45'h1, 3);
    end
  endtask
  task t_req;
    begin
      ev(1, 8'h01, 8'h03, 45'h3 << 31, 3);
      ev(2, 8'h01, 8'h04, 45'h1 << 29, 3);
      ev(3, 8'h01, 8'h08, 45'h1 << 29, 0);
    end
  endtask
  // Credits arrive only while the clock enable is low, so a counter that ignores the enable reads non-zero.
  task t_freeze;
    begin
      wb(1, 8'h08, 32'h0002_0000);
      wb(1, 8'h08, 32'h0040_0059);
      occ_i <= 45'h2a << 39;
      act <= 1;
      ce_i <= 0;
      repeat (3) @(posedge clk_i);
      act <= 0;
      repeat (3) @(posedge clk_i);
      ce_i <= 1;
      @(posedge clk_i);
      wb(0, 8'h18, 0);
      chk("frozen", 0, rd);
    end
  endtask
  // A mid-run reset must clear both the control word and the count that it enabled.
  task t_reset;
    begin
      occ_i <= 45'h2a << 39;
      act <= 1;
      repeat (3) @(posedge clk_i);
      act <= 0;
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      wb(0, 8'h08, 0);
      chk("ctrl2", 0, rd);
      wb(0, 8'h18, 0);
      chk("cnt2", 0, rd);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    t_regs;
    t_dir;
    t_link;
    t_mem;
    t_spec;
    t_req;
    t_freeze;
    t_reset;
    results;
  end
endmodule
